// file: core/sysclk_dist_pkg.sv
package sysclk_dist_pkg;
	// ---------------------------------------------
	// Bus widths
	// ---------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [15:0] OFS_MULT_CFG = 16'h0100;
	localparam logic [15:0] OFS_FB_DIV = 16'h0101;
	localparam logic [15:0] OFS_MULT_CTRL = 16'h0102;
	localparam logic [15:0] OFS_PERIOD_B0 = 16'h0103;
	localparam logic [15:0] OFS_PERIOD_B1 = 16'h0104;
	localparam logic [15:0] OFS_PERIOD_B2 = 16'h0105;
	localparam logic [15:0] OFS_DUR_B0 = 16'h0106;
	localparam logic [15:0] OFS_DUR_B1 = 16'h0107;
	localparam logic [15:0] OFS_DUR_B2 = 16'h0108;
	localparam logic [15:0] OFS_IRQ_MASK = 16'h0209;
	localparam logic [15:0] OFS_DIST_SET = 16'h0400;
	localparam logic [15:0] OFS_DIST_OE = 16'h0401;
	localparam logic [15:0] OFS_DIV0_B0 = 16'h0408;
	localparam logic [15:0] OFS_DIV1_B0 = 16'h040c;
	localparam logic [15:0] OFS_CAL_CTRL = 16'h0a02;
	localparam logic [15:0] OFS_SYS_STATUS = 16'h0d01;
	localparam logic [15:0] OFS_IRQ_MON = 16'h0d02;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int CFG_EXT_LF_BIT = 7;
	localparam int CFG_CP_MODE_BIT = 6;
	localparam int CFG_CP_LSB = 3;
	localparam int CFG_LD_DIS_BIT = 2;
	localparam int CFG_LD_DIV_LSB = 0;
	localparam int CTRL_EN_BIT = 0;
	localparam int DIST_PD0_BIT = 0;
	localparam int DIST_PD1_BIT = 1;
	localparam int DIST_INV0_BIT = 2;
	localparam int DIST_INV1_BIT = 3;
	localparam int DIST_HF_RX_BIT = 4;
	localparam int OE_CH0_BIT = 0;
	localparam int OE_CH1_BIT = 1;
	localparam int CAL_BIT = 0;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_CAL_BIT = 1;
	localparam int ST_STABLE_BIT = 4;
	localparam int MON_CAL_BIT = 1;
	localparam int MASK_CAL_BIT = 1;
	// ---------------------------------------------
	// Reset values
	// ---------------------------------------------
	localparam logic [7:0] CFG_RST = 8'h18;
	localparam logic [7:0] FB_DIV_RST = 8'h28;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [23:0] PERIOD_RST = 24'h0f_4240;
	localparam logic [23:0] DUR_RST = 24'h00_0000;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] DIST_SET_RST = 8'h00;
	localparam logic [7:0] DIST_OE_RST = 8'h00;
	localparam logic [31:0] DIV_RST = 32'h0000_0000;
	// ---------------------------------------------
	// Timing and counts
	// ---------------------------------------------
	localparam logic [40:0] FS_PER_MS = 41'h00e8_d4a5_1000;
	localparam logic [10:0] LD_BASE_RUN = 11'h080;
	localparam int CAL_CYCLES_DEF = 1024;
	typedef enum logic [1:0] {TM_IDLE, TM_COUNT, TM_DONE} timer_state_t;
endpackage : sysclk_dist_pkg

// file: core/chan_divider.sv
`timescale 1ns/100ps
module chan_divider
	import sysclk_dist_pkg::*;
#(
	parameter int DIV_W = 30
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hold,
	input wire logic [DIV_W-1:0] div_val,
	input wire logic enable_req,
	input wire logic invert,
	output logic out_hi,
	output logic out_lo
);
	// ---------------------------------------------
	// Period counter
	// ---------------------------------------------
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic [DIV_W-1:0] half;
	logic [DIV_W:0] ratio;
	logic odd_ratio;
	logic en_act_r;
	logic en_use;
	logic hi_lvl;
	logic lo_lvl;

	assign ratio = {1'b0, div_val} + {{DIV_W{1'b0}}, 1'b1};
	assign half = ratio[DIV_W:1];
	assign odd_ratio = ratio[0];
	assign cnt_nxt = (cnt_r >= div_val) ? '0 : cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
	// Even: equal halves; odd: out_hi high half one input cycle longer, out_lo low half one input cycle longer
	assign lo_lvl = (cnt_nxt < half);
	assign hi_lvl = odd_ratio ? (cnt_nxt <= half) : (cnt_nxt < half);
	// Enable changes take effect only at period start
	assign en_use = (cnt_nxt == '0) ? enable_req : en_act_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (hold) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_act_r <= 1'b0;
		end else if (hold) begin
			en_act_r <= 1'b0;
		end else begin
			en_act_r <= en_use;
		end
	end

	// ---------------------------------------------
	// Output phases, static level when stalled
	// ---------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else if (hold) begin
			out_hi <= invert;
			out_lo <= invert;
		end else begin
			out_hi <= (en_use & hi_lvl) ^ invert;
			out_lo <= (en_use & lo_lvl) ^ invert;
		end
	end
endmodule : chan_divider

// file: core/sysclk_dist_ctrl.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module sysclk_dist_ctrl
	import sysclk_dist_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CYCLES_DEF,
	parameter int DIV_W = 30,
	parameter int DUR_W = 20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic pfd_sample,
	input wire logic pfd_in_phase,
	output logic [2:0] cp_current_code,
	output logic ext_loop_filter,
	output logic multiplier_enable,
	output logic vco_cal_active,
	output logic sysclk_locked,
	output logic sysclk_stable,
	output logic ref_monitor_enable,
	output logic hf_receiver_select,
	output logic [1:0] driver_powerdown,
	output logic deep_sleep,
	output logic [1:0] out_hi,
	output logic [1:0] out_lo
);
	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	logic [7:0] cfg_r;
	logic [7:0] fb_div_r;
	logic [7:0] ctrl_r;
	logic [23:0] period_r;
	logic [23:0] dur_r;
	logic [7:0] mask_r;
	logic [7:0] dist_set_r;
	logic [7:0] dist_oe_r;
	logic [31:0] div0_r;
	logic [31:0] div1_r;
	logic [7:0] cal_ctrl_r;
	logic [7:0] rdata_nxt;
	logic [7:0] status;
	logic [7:0] monitor;

	function automatic logic [31:0] put_byte(input logic [31:0] cur, input logic [1:0] idx,
		input logic [7:0] val);
		logic [31:0] res;
		res = cur;
		res[idx*8 +: 8] = val;
		return res;
	endfunction : put_byte

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= CFG_RST;
			fb_div_r <= FB_DIV_RST;
			ctrl_r <= CTRL_RST;
			period_r <= PERIOD_RST;
			dur_r <= DUR_RST;
			mask_r <= MASK_RST;
			dist_set_r <= DIST_SET_RST;
			dist_oe_r <= DIST_OE_RST;
			div0_r <= DIV_RST;
			div1_r <= DIV_RST;
		end else if (wr) begin
			unique case (addr)
				OFS_MULT_CFG: cfg_r <= wdata;
				OFS_FB_DIV: fb_div_r <= wdata;
				OFS_MULT_CTRL: ctrl_r <= wdata;
				OFS_PERIOD_B0: period_r[7:0] <= wdata;
				OFS_PERIOD_B1: period_r[15:8] <= wdata;
				OFS_PERIOD_B2: period_r[23:16] <= wdata;
				OFS_DUR_B0: dur_r[7:0] <= wdata;
				OFS_DUR_B1: dur_r[15:8] <= wdata;
				OFS_DUR_B2: dur_r[23:16] <= wdata;
				OFS_IRQ_MASK: mask_r <= wdata;
				OFS_DIST_SET: dist_set_r <= wdata;
				OFS_DIST_OE: dist_oe_r <= wdata;
				OFS_DIV0_B0, OFS_DIV0_B0 + 16'h0001, OFS_DIV0_B0 + 16'h0002,
				OFS_DIV0_B0 + 16'h0003: begin
					div0_r <= put_byte(div0_r, addr[1:0], wdata);
				end
				OFS_DIV1_B0, OFS_DIV1_B0 + 16'h0001, OFS_DIV1_B0 + 16'h0002,
				OFS_DIV1_B0 + 16'h0003: begin
					div1_r <= put_byte(div1_r, addr[1:0], wdata);
				end
				default: ;
			endcase
		end
	end

	// ---------------------------------------------
	// Calibration trigger on set-then-clear
	// ---------------------------------------------
	logic cal_wr;
	logic cal_start;
	logic [31:0] cal_cnt_r;

	assign cal_wr = wr && (addr == OFS_CAL_CTRL);
	assign cal_start = cal_wr && cal_ctrl_r[CAL_BIT] && !wdata[CAL_BIT];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_ctrl_r <= 8'h00;
		end else if (cal_wr) begin
			cal_ctrl_r <= {7'h00, wdata[CAL_BIT]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_cnt_r <= 32'h0000_0000;
			vco_cal_active <= 1'b0;
		end else if (cal_start) begin
			cal_cnt_r <= 32'(CAL_CYCLES - 1);
			vco_cal_active <= 1'b1;
		end else if (cal_cnt_r != 32'h0000_0000) begin
			cal_cnt_r <= cal_cnt_r - 32'h0000_0001;
		end else begin
			vco_cal_active <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Charge pump, filter, enables
	// ---------------------------------------------
	function automatic logic [2:0] auto_cp(input logic [7:0] n);
		if (n < 8'h40) begin
			return 3'h1;
		end else if (n < 8'h80) begin
			return 3'h3;
		end
		return 3'h7;
	endfunction : auto_cp

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cp_current_code <= CFG_RST[CFG_CP_LSB +: 3];
			ext_loop_filter <= 1'b0;
			multiplier_enable <= 1'b0;
			hf_receiver_select <= 1'b0;
			driver_powerdown <= 2'b00;
			deep_sleep <= 1'b0;
		end else begin
			cp_current_code <= cfg_r[CFG_CP_MODE_BIT] ? cfg_r[CFG_CP_LSB +: 3]
				: auto_cp(fb_div_r);
			ext_loop_filter <= cfg_r[CFG_EXT_LF_BIT];
			multiplier_enable <= ctrl_r[CTRL_EN_BIT];
			hf_receiver_select <= dist_set_r[DIST_HF_RX_BIT];
			driver_powerdown <= {dist_set_r[DIST_PD1_BIT], dist_set_r[DIST_PD0_BIT]};
			deep_sleep <= dist_set_r[DIST_PD1_BIT] & dist_set_r[DIST_PD0_BIT];
		end
	end

	// ---------------------------------------------
	// Lock detector
	// ---------------------------------------------
	logic ld_enable;
	logic [10:0] ld_cnt_r;
	logic [10:0] ld_target;

	assign ld_enable = !cfg_r[CFG_LD_DIS_BIT] && multiplier_enable && !vco_cal_active;
	assign ld_target = LD_BASE_RUN << cfg_r[CFG_LD_DIV_LSB +: 2];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ld_cnt_r <= 11'h000;
			sysclk_locked <= 1'b0;
		end else if (!ld_enable) begin
			ld_cnt_r <= 11'h000;
			sysclk_locked <= 1'b0;
		end else if (pfd_sample) begin
			if (!pfd_in_phase) begin
				ld_cnt_r <= 11'h000;
				sysclk_locked <= 1'b0;
			end else if (ld_cnt_r + 11'h001 >= ld_target) begin
				ld_cnt_r <= ld_target;
				sysclk_locked <= 1'b1;
			end else begin
				ld_cnt_r <= ld_cnt_r + 11'h001;
			end
		end
	end

	// ---------------------------------------------
	// Stability timer
	// ---------------------------------------------
	timer_state_t tm_state_r;
	logic [40:0] acc_r;
	logic [40:0] acc_sum;
	logic ms_tick;
	logic [DUR_W-1:0] ms_cnt_r;
	logic [DUR_W-1:0] dur_ms;
	logic tm_run;
	logic en_prev_r;
	logic en_fall;

	assign dur_ms = dur_r[DUR_W-1:0];
	assign tm_run = multiplier_enable ? sysclk_locked : 1'b1;
	assign en_fall = en_prev_r && !multiplier_enable;
	assign acc_sum = acc_r + {17'h0_0000, period_r};
	assign ms_tick = (acc_sum >= FS_PER_MS);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_prev_r <= 1'b0;
		end else begin
			en_prev_r <= multiplier_enable;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tm_state_r <= TM_IDLE;
			acc_r <= '0;
			ms_cnt_r <= '0;
			sysclk_stable <= 1'b0;
		end else if (dur_ms == '0) begin
			tm_state_r <= TM_DONE;
			sysclk_stable <= 1'b1;
		end else if (!tm_run || en_fall) begin
			tm_state_r <= TM_IDLE;
			acc_r <= '0;
			ms_cnt_r <= '0;
			sysclk_stable <= 1'b0;
		end else begin
			unique case (tm_state_r)
				TM_IDLE: begin
					tm_state_r <= TM_COUNT;
					acc_r <= '0;
					ms_cnt_r <= '0;
					sysclk_stable <= 1'b0;
				end
				TM_COUNT: begin
					acc_r <= ms_tick ? acc_sum - FS_PER_MS : acc_sum;
					if (ms_tick) begin
						ms_cnt_r <= ms_cnt_r + {{(DUR_W-1){1'b0}}, 1'b1};
						if (ms_cnt_r + {{(DUR_W-1){1'b0}}, 1'b1} >= dur_ms) begin
							tm_state_r <= TM_DONE;
							sysclk_stable <= 1'b1;
						end
					end
				end
				TM_DONE: sysclk_stable <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_monitor_enable <= 1'b0;
		end else begin
			ref_monitor_enable <= sysclk_stable;
		end
	end

	// ---------------------------------------------
	// Status and readback
	// ---------------------------------------------
	always_comb begin
		status = 8'h00;
		status[ST_LOCK_BIT] = sysclk_locked;
		status[ST_CAL_BIT] = vco_cal_active;
		status[ST_STABLE_BIT] = sysclk_stable;
		monitor = 8'h00;
		monitor[MON_CAL_BIT] = vco_cal_active & mask_r[MASK_CAL_BIT];
	end

	always_comb begin
		rdata_nxt = 8'h00;
		unique case (addr)
			OFS_MULT_CFG: rdata_nxt = cfg_r;
			OFS_FB_DIV: rdata_nxt = fb_div_r;
			OFS_MULT_CTRL: rdata_nxt = ctrl_r;
			OFS_PERIOD_B0: rdata_nxt = period_r[7:0];
			OFS_PERIOD_B1: rdata_nxt = period_r[15:8];
			OFS_PERIOD_B2: rdata_nxt = period_r[23:16];
			OFS_DUR_B0: rdata_nxt = dur_r[7:0];
			OFS_DUR_B1: rdata_nxt = dur_r[15:8];
			OFS_DUR_B2: rdata_nxt = dur_r[23:16];
			OFS_IRQ_MASK: rdata_nxt = mask_r;
			OFS_DIST_SET: rdata_nxt = dist_set_r;
			OFS_DIST_OE: rdata_nxt = dist_oe_r;
			OFS_DIV0_B0, OFS_DIV0_B0 + 16'h0001, OFS_DIV0_B0 + 16'h0002,
			OFS_DIV0_B0 + 16'h0003: rdata_nxt = div0_r[addr[1:0]*8 +: 8];
			OFS_DIV1_B0, OFS_DIV1_B0 + 16'h0001, OFS_DIV1_B0 + 16'h0002,
			OFS_DIV1_B0 + 16'h0003: rdata_nxt = div1_r[addr[1:0]*8 +: 8];
			OFS_CAL_CTRL: rdata_nxt = cal_ctrl_r;
			OFS_SYS_STATUS: rdata_nxt = status;
			OFS_IRQ_MON: rdata_nxt = monitor;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= rdata_nxt;
		end else begin
			rdata <= 8'h00;
		end
	end

	// ---------------------------------------------
	// Output channels
	// ---------------------------------------------
	logic [1:0] oe_bits;
	logic [1:0] inv_bits;
	logic [DIV_W-1:0] div_vals [2];

	assign oe_bits = {dist_oe_r[OE_CH1_BIT], dist_oe_r[OE_CH0_BIT]};
	assign inv_bits = {dist_set_r[DIST_INV1_BIT], dist_set_r[DIST_INV0_BIT]};
	assign div_vals[0] = div0_r[DIV_W-1:0];
	assign div_vals[1] = div1_r[DIV_W-1:0];

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		chan_divider #(
			.DIV_W(DIV_W)
		) u_div (
			.clk(clk),
			.resetn(resetn),
			.hold(deep_sleep),
			.div_val(div_vals[ch]),
			.enable_req(oe_bits[ch]),
			.invert(inv_bits[ch]),
			.out_hi(out_hi[ch]),
			.out_lo(out_lo[ch])
		);
	end
endmodule : sysclk_dist_ctrl

// file: verification/sysclk_dist_ctrl_chk.sv
`timescale 1ns/100ps
module sysclk_dist_ctrl_chk
	import sysclk_dist_pkg::*;
#(
	parameter int CAL_CYCLES = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic pfd_sample,
	input wire logic pfd_in_phase,
	input wire logic [2:0] cp_current_code,
	input wire logic ext_loop_filter,
	input wire logic vco_cal_active,
	input wire logic sysclk_locked,
	input wire logic sysclk_stable,
	input wire logic ref_monitor_enable,
	input wire logic hf_receiver_select,
	input wire logic [1:0] driver_powerdown,
	input wire logic deep_sleep
);
	// ----
	// Helper state
	// ----
	logic cal_set_r;
	logic [2:0] dz_r;
	logic [11:0] run_r;
	logic [15:0] cal_cnt_r;
	logic clr_wr;
	assign clr_wr = wr && addr == OFS_CAL_CTRL && !wdata[CAL_BIT] && cal_set_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_set_r <= 1'b0;
			dz_r <= 3'h7;
			run_r <= 12'h000;
			cal_cnt_r <= 16'h0000;
		end else begin
			if (wr && addr == OFS_CAL_CTRL)
				cal_set_r <= wdata[CAL_BIT];
			if (wr && addr == OFS_DUR_B0)
				dz_r[0] <= wdata == 8'h00;
			if (wr && addr == OFS_DUR_B1)
				dz_r[1] <= wdata == 8'h00;
			if (wr && addr == OFS_DUR_B2)
				dz_r[2] <= wdata[3:0] == 4'h0;
			if (pfd_sample)
				run_r <= !pfd_in_phase ? 12'h000 : run_r + {11'h000, ~&run_r};
			cal_cnt_r <= vco_cal_active ? cal_cnt_r + 16'h0001 : 16'h0000;
		end
	end
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_clear_write;
		clr_wr;
	endsequence
	sequence s_cfg_write;
		wr && addr == OFS_MULT_CFG;
	endsequence
	a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_cal_start: assert property (s_clear_write |-> ##[1:2] vco_cal_active)
		else $error("calibration did not start");
	a_cal_cause: assert property ($rose(vco_cal_active) |-> $past(clr_wr) || $past(clr_wr, 2))
		else $error("calibration started without trigger");
	a_cal_length: assert property ($fell(vco_cal_active) |->
		cal_cnt_r >= CAL_CYCLES - 1 && cal_cnt_r <= CAL_CYCLES + 1)
		else $error("calibration length wrong");
	a_lock_run: assert property ($rose(sysclk_locked) |-> run_r >= 12'h080)
		else $error("lock too early");
	a_lock_clear: assert property (pfd_sample && !pfd_in_phase |-> ##[1:2] !sysclk_locked)
		else $error("lock kept after out of phase");
	a_cp_manual: assert property (s_cfg_write ##0 wdata[CFG_CP_MODE_BIT] |=>
		##1 cp_current_code == $past(wdata[5:3], 2))
		else $error("manual pump code wrong");
	a_ext_filter: assert property (s_cfg_write |=> ##1 ext_loop_filter == $past(wdata[7], 2))
		else $error("filter select wrong");
	a_hf_receiver: assert property (wr && addr == OFS_DIST_SET |=>
		##1 hf_receiver_select == $past(wdata[4], 2))
		else $error("receiver select wrong");
	a_deep_sleep: assert property (deep_sleep == &driver_powerdown)
		else $error("deep sleep wrong");
	a_sleep_write: assert property (wr && addr == OFS_DIST_SET |=>
		##1 deep_sleep == &$past(wdata[1:0], 2))
		else $error("deep sleep not from power-down bits");
	a_ref_monitor: assert property (ref_monitor_enable == $past(sysclk_stable))
		else $error("monitor enable wrong");
	a_zero_dur: assert property ((&dz_r) [*3] |-> sysclk_stable)
		else $error("zero duration not stable");
endmodule : sysclk_dist_ctrl_chk
bind sysclk_dist_ctrl sysclk_dist_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) sysclk_dist_ctrl_chk_i (
	.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .pfd_sample, .pfd_in_phase,
	.cp_current_code, .ext_loop_filter, .vco_cal_active, .sysclk_locked, .sysclk_stable,
	.ref_monitor_enable, .hf_receiver_select, .driver_powerdown, .deep_sleep
);

// file: verification/sysclk_dist_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("unexpected %s exp %h got %h", n, e, g); \
	end \
end
module sysclk_dist_ctrl_tb_top;
	import sysclk_dist_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, pfd_sample = 1'b0, pfd_in_phase = 1'b0;
	logic [7:0] rdata;
	logic [2:0] cp_current_code;
	logic ext_loop_filter, multiplier_enable, vco_cal_active, sysclk_locked;
	logic sysclk_stable, ref_monitor_enable, hf_receiver_select, deep_sleep;
	logic [1:0] driver_powerdown, out_hi, out_lo;
	int bad_count = 0;
	int total_checks = 0;
	sysclk_dist_ctrl #(.CAL_CYCLES(8)) sysclk_dist_ctrl_i (
		.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .pfd_sample, .pfd_in_phase,
		.cp_current_code, .ext_loop_filter, .multiplier_enable, .vco_cal_active,
		.sysclk_locked, .sysclk_stable, .ref_monitor_enable, .hf_receiver_select,
		.driver_powerdown, .deep_sleep, .out_hi, .out_lo
	);
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ----
	// Tasks
	// ----
	task automatic report_and_stop;
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd_chk
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic pfd(input int n, input logic ph);
		repeat (n) begin
			@(posedge clk);
			pfd_sample <= 1'b1;
			pfd_in_phase <= ph;
			@(posedge clk);
			pfd_sample <= 1'b0;
		end
		settle();
	endtask : pfd
	task automatic div_case(input logic [7:0] d0, d1, st, oe, input int h0, l0, h1, l1);
		int c[6];
		wr_reg(OFS_DIST_SET, 8'h03);
		wr_reg(OFS_DIV0_B0, d0);
		wr_reg(OFS_DIV1_B0, d1);
		wr_reg(OFS_DIST_OE, oe);
		wr_reg(OFS_DIST_SET, st);
		repeat (12) @(posedge clk);
		c = '{default: 0};
		repeat (20) begin
			@(posedge clk);
			#1;
			c[0] += (out_hi[0] === 1'b1);
			c[1] += (out_lo[0] === 1'b1);
			c[2] += (out_hi[1] === 1'b1);
			c[3] += (out_lo[1] === 1'b1);
			c[4] += (^{out_hi, out_lo} !== 1'bx);
			c[5] += (out_hi[0] === out_hi[1]);
		end
		`CHK("ch0 high", h0, c[0])
		`CHK("ch0 low", l0, c[1])
		`CHK("ch1 high", h1, c[2])
		`CHK("ch1 low", l1, c[3])
		`CHK("known", 20, c[4])
		if (d0 == d1) `CHK("unison", 20, c[5])
	endtask : div_case
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		settle();
		`CHK("cp code", 3'h1, cp_current_code)
		`CHK("stable", 1'b1, sysclk_stable)
		`CHK("ref mon", 1'b1, ref_monitor_enable)
		rd_chk(OFS_MULT_CFG, 8'h18);
		rd_chk(OFS_PERIOD_B0, 8'h40);
		wr_reg(OFS_SYS_STATUS, 8'hff);
		rd_chk(OFS_SYS_STATUS, 8'h10);
		rd_chk(16'h0000, 8'h00);
		wr_reg(OFS_MULT_CFG, 8'he8);
		settle();
		`CHK("cp code", 3'h5, cp_current_code)
		`CHK("ext lf", 1'b1, ext_loop_filter)
		wr_reg(OFS_MULT_CFG, 8'h28);
		wr_reg(OFS_FB_DIV, 8'hc8);
		settle();
		`CHK("cp code", 3'h7, cp_current_code)
		`CHK("ext lf", 1'b0, ext_loop_filter)
		wr_reg(OFS_FB_DIV, 8'h50);
		settle();
		`CHK("cp code", 3'h3, cp_current_code)
		wr_reg(OFS_DIST_SET, 8'h13);
		settle();
		`CHK("hf rx", 1'b1, hf_receiver_select)
		`CHK("sleep", 1'b1, deep_sleep)
		wr_reg(OFS_DIST_SET, 8'h02);
		settle();
		`CHK("pd", 2'h2, driver_powerdown)
		`CHK("sleep", 1'b0, deep_sleep)
		for (int m = 0; m < 2; m++) begin
			wr_reg(OFS_IRQ_MASK, 8'(m * 2));
			wr_reg(OFS_CAL_CTRL, 8'h01);
			settle();
			`CHK("cal", 1'b0, vco_cal_active)
			wr_reg(OFS_CAL_CTRL, 8'h00);
			rd_chk(OFS_SYS_STATUS, 8'h12);
			rd_chk(OFS_IRQ_MON, 8'(m * 2));
			repeat (12) @(posedge clk);
			rd_chk(OFS_SYS_STATUS, 8'h10);
		end
		wr_reg(OFS_DUR_B0, 8'h01);
		wr_reg(OFS_MULT_CTRL, 8'h01);
		settle();
		`CHK("mult en", 1'b1, multiplier_enable)
		`CHK("stable", 1'b0, sysclk_stable)
		pfd(127, 1'b1);
		`CHK("locked", 1'b0, sysclk_locked)
		`CHK("ref mon", 1'b0, ref_monitor_enable)
		pfd(1, 1'b0);
		pfd(128, 1'b1);
		`CHK("locked", 1'b1, sysclk_locked)
		rd_chk(OFS_SYS_STATUS, 8'h01);
		pfd(1, 1'b0);
		`CHK("locked", 1'b0, sysclk_locked)
		wr_reg(OFS_MULT_CFG, 8'h2c);
		pfd(128, 1'b1);
		`CHK("locked", 1'b0, sysclk_locked)
		wr_reg(OFS_MULT_CFG, 8'h29);
		pfd(255, 1'b1);
		`CHK("locked", 1'b0, sysclk_locked)
		pfd(1, 1'b1);
		`CHK("locked", 1'b1, sysclk_locked)
		wr_reg(OFS_MULT_CTRL, 8'h00);
		settle();
		`CHK("stable", 1'b0, sysclk_stable)
		wr_reg(OFS_DUR_B0, 8'h00);
		settle();
		`CHK("stable", 1'b1, sysclk_stable)
		`CHK("ref mon", 1'b1, ref_monitor_enable)
		div_case(8'h03, 8'h04, 8'h00, 8'h03, 10, 10, 12, 8);
		div_case(8'h03, 8'h04, 8'h0c, 8'h03, 10, 10, 8, 12);
		div_case(8'h00, 8'h03, 8'h08, 8'h01, 20, 0, 20, 20);
		div_case(8'h03, 8'h03, 8'h00, 8'h03, 10, 10, 10, 10);
		report_and_stop();
	end
endmodule : sysclk_dist_ctrl_tb_top
